// ### design/egm_pkg.sv
// Purpose: Shared constants and carriers for the echo group main control block
// Assumes: One group of two cancellers (A at index 0, B at index 1)
// Notes: Register offsets are the pin address of the 6-bit host bus
package egm_pkg;
  // Register offsets on the host address pins
  localparam logic [5:0] ADDR_CTRL_A = 6'h00;
  localparam logic [5:0] ADDR_CTRL_B = 6'h20;
  // Values after reset and after an initialization
  localparam logic [7:0] RST_CTRL_A = 8'h00;
  localparam logic [7:0] RST_CTRL_B = 8'h02;
  // Field positions in the main control byte
  localparam int BIT_INIT = 7;
  localparam int BIT_NOISE_OFF = 6;
  localparam int BIT_B2B = 5;
  localparam int BIT_ATTEN = 4;
  localparam int BIT_BYPASS = 3;
  localparam int BIT_ADAPT_OFF = 2;
  localparam int BIT_CASCADE = 0;
  // Frames an initialization keeps coefficients clear; init_busy is set for the first frame only
  localparam logic [1:0] INIT_FRAMES = 2'h2;
  // Arithmetic shift giving 12 dB of receive attenuation (factor of four)
  localparam int ATTEN_SHIFT = 2;
  // Value read back from an unmapped address
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // Host bus pins and frame pulse, carried together through the synchroniser
  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic [5:0] addr;
    logic [7:0] din;
    logic frame;
  } egm_pins_t;

  // One PCM slot as it arrives, with the cancelling datapath's results
  typedef struct packed {
    logic chan_b;
    logic signed [15:0] rin;
    logic signed [15:0] sin;
    logic signed [15:0] ec_rout;
    logic signed [15:0] ec_sout;
  } egm_slot_in_t;

  // One PCM slot leaving the block
  typedef struct packed {
    logic chan_b;
    logic signed [15:0] rout;
    logic signed [15:0] sout;
  } egm_slot_out_t;

  // Frame-aligned settings handed to the cancelling datapath
  typedef struct packed {
    logic noise_on;
    logic atten;
    logic bypass;
    logic adapt_on;
    logic coef_clear;
    logic init_busy;
  } egm_ctrl_t;
endpackage

// ### design/egm_main_control.sv
// Purpose: Main control bytes of one canceller pair and the PCM output selection
// Assumes: Host pins and frame pulse are asynchronous; PCM slots are on core_clk
// Notes: Control reaches the datapath only at frame boundaries
// Functional notes
// - Writing init bit restores defaults, self-clears
// - Noise-off bit stops comfort noise injection
// - Back-to-back bit selects back-to-back configuration
// - Attenuate bit cuts receive path 12 dB
// - Bypass passes inputs, zeroes coefficients, stops adapting
// - Adapt-off freezes adaptation, cancelling continues
// - Cascade bit joins A and B, 128 ms
// - Joined configurations: B slot carries don't-care data
// - Initialization completes within two frames
module egm_main_control (
  input wire logic core_clk,
  input wire logic rst,
  // Host bus pins
  input wire logic host_cs_n,
  input wire logic host_wr_n,
  input wire logic host_rd_n,
  input wire logic [5:0] host_addr,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out_ff,
  output logic host_data_oe_n_ff,
  // Frame pulse pin
  input wire logic frame_pulse,
  // PCM slots in, with datapath results
  input wire egm_pkg::egm_slot_in_t slot_in,
  input wire logic slot_in_valid,
  output logic slot_in_ready_ff,
  // PCM slots out
  output egm_pkg::egm_slot_out_t slot_out_ff,
  output logic slot_out_valid_ff,
  input wire logic slot_out_ready,
  // Settings to the cancelling datapath
  output egm_pkg::egm_ctrl_t [1:0] ec_ctrl_ff,
  output logic back_to_back_ff,
  output logic tail_cascade_ff
);

  egm_pkg::egm_pins_t pins_now; // Pin bundle before synchronising
  egm_pkg::egm_pins_t sync1_ff; // First stage, read only by the second
  egm_pkg::egm_pins_t sync2_ff; // Stable copy of the pins
  egm_pkg::egm_pins_t prev_ff; // Previous stable copy, for edges
  logic wr_go; // One-cycle write strobe
  logic rd_on; // Read access active
  logic frame_go; // One-cycle frame boundary
  logic [7:0] ctrl_ff [2]; // Host-visible control bytes
  logic [1:0] init_cnt_ff [2]; // Frames left in an initialization
  logic [1:0] init_req; // Init bit written this cycle

  assign pins_now = '{cs_n: host_cs_n, wr_n: host_wr_n, rd_n: host_rd_n,
                      addr: host_addr, din: host_data_in, frame: frame_pulse};

  // Two-stage synchroniser on every pin, plus a history stage for edges
  // Every pin passes the same two stages, so the bundle stays aligned
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_ff <= '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, addr: '0, din: '0, frame: 1'b0};
      sync2_ff <= '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, addr: '0, din: '0, frame: 1'b0};
      prev_ff <= '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, addr: '0, din: '0, frame: 1'b0};
    end else begin
      sync1_ff <= pins_now;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  // Address and data are assumed stable while the strobe is low
  // A write fires once, on the synced falling edge of the write strobe
  // Limitation: a strobe low for under one clock may never be seen
  assign wr_go = !sync2_ff.cs_n && !sync2_ff.wr_n && prev_ff.wr_n;
  assign rd_on = !sync2_ff.cs_n && !sync2_ff.rd_n;
  assign frame_go = sync2_ff.frame && !prev_ff.frame;

  // Per-canceller control byte and initialization timer
  for (genvar c = 0; c < 2; c++) begin : g_ec
    localparam logic [5:0] MY_ADDR = (c == 0) ? egm_pkg::ADDR_CTRL_A : egm_pkg::ADDR_CTRL_B;
    localparam logic [7:0] MY_RST = (c == 0) ? egm_pkg::RST_CTRL_A : egm_pkg::RST_CTRL_B;

    assign init_req[c] = wr_go && (sync2_ff.addr == MY_ADDR)
                         && sync2_ff.din[egm_pkg::BIT_INIT];

    // Host write; an init write leaves the defaults, bit 7 included
    always_ff @(posedge core_clk) begin
      if (rst) begin
        ctrl_ff[c] <= MY_RST;
      end else if (init_req[c]) begin
        ctrl_ff[c] <= MY_RST;
      end else if (wr_go && (sync2_ff.addr == MY_ADDR)) begin
        ctrl_ff[c] <= sync2_ff.din;
      end
    end

    // Counts frame boundaries until the routine is done
    // A fresh init write restarts the count; it wins over a frame boundary
    always_ff @(posedge core_clk) begin
      if (rst) begin
        init_cnt_ff[c] <= '0;
      end else if (init_req[c]) begin
        init_cnt_ff[c] <= egm_pkg::INIT_FRAMES;
      end else if (frame_go && (init_cnt_ff[c] != '0)) begin
        init_cnt_ff[c] <= init_cnt_ff[c] - 2'h1;
      end
    end

    // Settings move to the datapath only on a frame boundary
    always_ff @(posedge core_clk) begin
      if (rst) begin
        ec_ctrl_ff[c] <= '0;
      end else if (frame_go) begin
        ec_ctrl_ff[c].noise_on <= !ctrl_ff[c][egm_pkg::BIT_NOISE_OFF];
        ec_ctrl_ff[c].atten <= ctrl_ff[c][egm_pkg::BIT_ATTEN];
        ec_ctrl_ff[c].bypass <= ctrl_ff[c][egm_pkg::BIT_BYPASS];
        // Bypass and initialization both stop adaptation
        // Adaptation stays off for the whole routine, not only while busy
        ec_ctrl_ff[c].adapt_on <= !ctrl_ff[c][egm_pkg::BIT_ADAPT_OFF]
                                  && !ctrl_ff[c][egm_pkg::BIT_BYPASS]
                                  && (init_cnt_ff[c] == '0);
        // Coefficients held at zero in bypass and while initializing
        ec_ctrl_ff[c].coef_clear <= ctrl_ff[c][egm_pkg::BIT_BYPASS]
                                    || (init_cnt_ff[c] != '0);
        ec_ctrl_ff[c].init_busy <= (init_cnt_ff[c] > 2'h1);
      end
    end
  end

  // Group configuration, taken from canceller A, applied per frame
  // Canceller B's copy of the back-to-back bit is stored and read back by the host but never applied
  always_ff @(posedge core_clk) begin
    if (rst) begin
      back_to_back_ff <= 1'b0;
      tail_cascade_ff <= 1'b0;
    end else if (frame_go) begin
      back_to_back_ff <= ctrl_ff[0][egm_pkg::BIT_B2B];
      tail_cascade_ff <= ctrl_ff[0][egm_pkg::BIT_CASCADE];
    end
  end

  // Read data and pin drive; an unmapped address reads zero
  // Data follows the synced address every cycle, so it is settled when drive starts
  always_ff @(posedge core_clk) begin
    if (rst) begin
      host_data_out_ff <= egm_pkg::RD_UNMAPPED;
      host_data_oe_n_ff <= 1'b1;
    end else begin
      host_data_oe_n_ff <= !rd_on;
      if (sync2_ff.addr == egm_pkg::ADDR_CTRL_A) begin
        host_data_out_ff <= ctrl_ff[0];
      end else if (sync2_ff.addr == egm_pkg::ADDR_CTRL_B) begin
        host_data_out_ff <= ctrl_ff[1];
      end else begin
        host_data_out_ff <= egm_pkg::RD_UNMAPPED;
      end
    end
  end

  // Output selection for the arriving slot
  // Each slot uses the frame-aligned settings of its own canceller
  egm_pkg::egm_slot_out_t sel; // Selected output slot
  egm_pkg::egm_ctrl_t cur; // Settings of the slot's canceller
  always_comb begin
    cur = ec_ctrl_ff[slot_in.chan_b];
    sel.chan_b = slot_in.chan_b;
    if (cur.bypass) begin
      sel.rout = slot_in.rin;
      sel.sout = slot_in.sin;
    end else begin
      sel.rout = slot_in.ec_rout;
      sel.sout = slot_in.ec_sout;
    end
    // Attenuation follows the bypass choice, so bypassed receive data is cut too
    if (cur.atten) begin
      sel.rout = sel.rout >>> egm_pkg::ATTEN_SHIFT;
    end
    // Joined modes leave B's slot unused; zero is a safe filler
    if (slot_in.chan_b && (back_to_back_ff || tail_cascade_ff)) begin
      sel.rout = '0;
      sel.sout = '0;
    end
  end

  // Two-entry skid buffer: the main stage plus one spare slot
  egm_pkg::egm_slot_out_t skid_ff; // Slot parked during a stall
  logic skid_valid_ff; // Spare slot occupied
  logic push; // Slot accepted this cycle
  logic drain; // Main stage free to take a slot
  assign push = slot_in_valid && slot_in_ready_ff;
  assign drain = !slot_out_valid_ff || slot_out_ready;

  // Ready is dropped while the spare is full, so a stall loses no slot
  // Registered ready costs a spare slot but keeps the input path short
  always_ff @(posedge core_clk) begin
    if (rst) begin
      slot_out_ff <= '0;
      slot_out_valid_ff <= 1'b0;
      skid_ff <= '0;
      skid_valid_ff <= 1'b0;
      slot_in_ready_ff <= 1'b1;
    end else if (drain) begin
      if (skid_valid_ff) begin
        slot_out_ff <= skid_ff;
        slot_out_valid_ff <= 1'b1;
        skid_valid_ff <= 1'b0;
        slot_in_ready_ff <= 1'b1;
      end else begin
        slot_out_ff <= sel;
        slot_out_valid_ff <= push;
      end
    end else if (push) begin
      skid_ff <= sel;
      skid_valid_ff <= 1'b1;
      slot_in_ready_ff <= 1'b0;
    end
  end

endmodule

// ### tb/egm_chk_asserts.sv
// Purpose: Port-level checks of the main control block
// Assumes: Bound onto egm_main_control; one clock domain
// Notes: Only slots that go straight to the output register are traced
module egm_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic host_cs_n,
  input wire logic host_rd_n,
  input wire logic host_data_oe_n_ff,
  input wire logic frame_pulse,
  input wire egm_pkg::egm_slot_in_t slot_in,
  input wire logic slot_in_valid,
  input wire logic slot_in_ready_ff,
  input wire egm_pkg::egm_slot_out_t slot_out_ff,
  input wire logic slot_out_valid_ff,
  input wire logic slot_out_ready,
  input wire egm_pkg::egm_ctrl_t [1:0] ec_ctrl_ff,
  input wire logic back_to_back_ff,
  input wire logic tail_cascade_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Slot accepted with an empty skid, so it lands in the output register next
  wire logic go = slot_in_valid && slot_in_ready_ff && (!slot_out_valid_ff || slot_out_ready);
  // Same, for a canceller A slot
  wire logic go_a = go && !slot_in.chan_b;
  a_oe_drive: assert property ((!host_cs_n && !host_rd_n) [*4] |=> !host_data_oe_n_ff)
    else $error("read enable not driven");
  a_ctrl_quiet: assert property (!frame_pulse [*6] |=>
    $stable({ec_ctrl_ff, back_to_back_ff, tail_cascade_ff}))
    else $error("settings moved without frame");
  a_bypass_pass: assert property (go_a && ec_ctrl_ff[0].bypass |=>
    slot_out_ff.sout == $past(slot_in.sin)
    && ($past(ec_ctrl_ff[0].atten) || slot_out_ff.rout == $past(slot_in.rin)))
    else $error("bypass data wrong");
  a_echo_path: assert property (go_a && !ec_ctrl_ff[0].bypass |=>
    slot_out_ff.sout == $past(slot_in.ec_sout)
    && ($past(ec_ctrl_ff[0].atten) || slot_out_ff.rout == $past(slot_in.ec_rout)))
    else $error("cancel data wrong");
  a_atten_rout: assert property (go_a && ec_ctrl_ff[0].atten |=>
    slot_out_ff.rout == (($past(ec_ctrl_ff[0].bypass) ? $past(slot_in.rin)
    : $past(slot_in.ec_rout)) >>> 2))
    else $error("receive gain wrong");
  a_b_filler: assert property (go && slot_in.chan_b
    && (back_to_back_ff || tail_cascade_ff)
    |=> slot_out_ff.rout == 16'sh0 && slot_out_ff.sout == 16'sh0)
    else $error("joined b slot not filled");
  a_stall_hold: assert property (slot_out_valid_ff && !slot_out_ready |=>
    slot_out_valid_ff && $stable(slot_out_ff)) else $error("stalled slot lost");
  a_skid_low: assert property (!slot_in_ready_ff |-> slot_out_valid_ff)
    else $error("ready low with empty output");
  a_bypass_frz: assert property (ec_ctrl_ff[0].bypass |->
    ec_ctrl_ff[0].coef_clear && !ec_ctrl_ff[0].adapt_on) else $error("bypass adapts");
  a_init_clear: assert property (ec_ctrl_ff[0].init_busy |->
    ec_ctrl_ff[0].coef_clear && !ec_ctrl_ff[0].adapt_on) else $error("init adapts");
endmodule

// ### tb/egm_host_model.sv
// Purpose: Host processor on the parallel pins, plus the frame source
// Assumes: Tasks are entered just after a clock edge
// Notes: Released address and data lines show the inverse of the last value
module egm_host_model (
  input wire logic core_clk,
  output logic host_cs_n,
  output logic host_wr_n,
  output logic host_rd_n,
  output logic [5:0] host_addr,
  output logic [7:0] host_data_in,
  output logic frame_pulse,
  input wire logic [7:0] rdata,
  input wire logic rd_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle pins at time zero
  initial begin
    {host_cs_n, host_wr_n, host_rd_n, host_addr, host_data_in, frame_pulse} = 18'h3fffe;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Strobes held three cycles low and three high, as the pin sync needs
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    host_addr <= a;
    host_data_in <= d;
    {host_cs_n, host_wr_n} <= 2'h0;
    cyc(3);
    {host_cs_n, host_wr_n} <= 2'h3;
    cyc(1);
    host_addr <= ~a;
    host_data_in <= ~d;
    cyc(2);
  endtask
  // Read data and enable sampled once they have settled
  task automatic rd(input logic [5:0] a, output logic [8:0] q);
    host_addr <= a;
    {host_cs_n, host_rd_n} <= 2'h0;
    cyc(4);
    q = {rd_oe_n, rdata};
    {host_cs_n, host_rd_n} <= 2'h3;
    host_addr <= ~a;
    cyc(4);
  endtask
  // One frame boundary
  task automatic tick;
    frame_pulse <= 1'b1;
    cyc(3);
    frame_pulse <= 1'b0;
    cyc(3);
  endtask
endmodule

// ### tb/tb.sv
// Purpose: Self-checking bench for the main control block
// Assumes: Host pins and slots driven at rising edges
// Notes: Expected slot values derive from ec outputs = inverted inputs
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cs_n, wr_n, rd_n, frame, iv, ir, ov, orr, b2b, casc, oe_n;
  logic [5:0] addr;
  logic [7:0] din, dout;
  logic [8:0] q;
  egm_pkg::egm_slot_in_t si;
  egm_pkg::egm_slot_out_t so;
  egm_pkg::egm_ctrl_t [1:0] ec;
  int n_errors = 0, check_count = 0, cycles = 0;
  logic [32:0] got_q [8]; // Slots taken downstream, in order
  int n_got = 0, n_used = 0; // Slots seen and slots compared
  initial forever #50 core_clk = ~core_clk;
  egm_host_model u_h (.core_clk(core_clk), .host_cs_n(cs_n), .host_wr_n(wr_n),
    .host_rd_n(rd_n), .host_addr(addr), .host_data_in(din), .frame_pulse(frame),
    .rdata(dout), .rd_oe_n(oe_n));
  egm_main_control DUT (.core_clk(core_clk), .rst(rst), .host_cs_n(cs_n), .host_wr_n(wr_n),
    .host_rd_n(rd_n), .host_addr(addr), .host_data_in(din), .host_data_out_ff(dout),
    .host_data_oe_n_ff(oe_n), .frame_pulse(frame), .slot_in(si), .slot_in_valid(iv),
    .slot_in_ready_ff(ir), .slot_out_ff(so), .slot_out_valid_ff(ov), .slot_out_ready(orr),
    .ec_ctrl_ff(ec), .back_to_back_ff(b2b), .tail_cascade_ff(casc));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [5:0] a, input logic [7:0] e);
    u_h.rd(a, q);
    chk(q, {1'b0, e});
  endtask
  task automatic push(input logic b, input logic [15:0] r, input logic [15:0] s);
    si <= '{b, r, s, ~r, ~s};
    iv <= 1'b1;
    @(posedge core_clk);
    while (!ir) @(posedge core_clk);
    iv <= 1'b0;
    @(posedge core_clk);
  endtask
  // Records every slot at the edge that hands it on, so none is missed
  always @(posedge core_clk) begin
    if (ov && orr) begin
      got_q[n_got % 8] <= {so.chan_b, so.rout, so.sout};
      n_got <= n_got + 1;
    end
  end
  // Waits for the next recorded output slot and compares it
  task automatic pull(input logic b, input logic [31:0] e);
    while (n_used >= n_got) @(posedge core_clk);
    chk(got_q[n_used % 8], {b, e});
    n_used++;
  endtask
  task automatic final_report;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Hang guard well above the expected two hundred or so cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      final_report;
    end
  end
  initial begin
    {iv, orr, si} = '0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rdc(6'h00, 8'h00);
    rdc(6'h20, 8'h02);
    rdc(6'h01, 8'h00);
    u_h.wr(6'h00, 8'h74);
    u_h.wr(6'h20, 8'h2a);
    rdc(6'h20, 8'h2a);
    chk({ec, b2b, casc}, 32'h0);
    u_h.tick;
    chk({ec, b2b, casc}, {6'b101010, 6'b010000, 2'b10});
    push(1'b0, 16'h1000, 16'h0123);
    push(1'b1, 16'h2222, 16'h3333);
    chk(ir, 1'b0);
    orr <= 1'b1;
    pull(1'b0, 32'hfbfffedc);
    pull(1'b1, 32'h0);
    u_h.wr(6'h00, 8'h08);
    u_h.tick;
    push(1'b0, 16'h1234, 16'h5678);
    pull(1'b0, 32'h12345678);
    u_h.wr(6'h00, 8'h00);
    u_h.tick;
    chk(ec[0], 6'b100100);
    u_h.wr(6'h20, 8'h02);
    u_h.wr(6'h00, 8'h01);
    u_h.tick;
    chk({b2b, casc}, 2'b01);
    push(1'b1, 16'h4444, 16'h5555);
    pull(1'b1, 32'h0);
    u_h.wr(6'h00, 8'h81);
    rdc(6'h00, 8'h00);
    u_h.tick;
    chk({ec[0], casc}, 7'b1000110);
    u_h.tick;
    chk(ec[0], 6'b100010);
    u_h.tick;
    chk(ec[0], 6'b100100);
    u_h.wr(6'h00, 8'h14);
    u_h.wr(6'h20, 8'h12);
    u_h.tick;
    chk(ec, {6'b110100, 6'b110000});
    // Reset in mid-run must bring bytes and settings back to defaults
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rdc(6'h00, egm_pkg::RST_CTRL_A);
    rdc(6'h20, egm_pkg::RST_CTRL_B);
    chk({ec, b2b, casc}, 32'h0);
    final_report;
  end
endmodule
bind egm_main_control egm_chk u_chk (.core_clk(core_clk), .rst(rst), .host_cs_n(host_cs_n),
  .host_rd_n(host_rd_n), .host_data_oe_n_ff(host_data_oe_n_ff), .frame_pulse(frame_pulse),
  .slot_in(slot_in), .slot_in_valid(slot_in_valid), .slot_in_ready_ff(slot_in_ready_ff),
  .slot_out_ff(slot_out_ff), .slot_out_valid_ff(slot_out_valid_ff),
  .slot_out_ready(slot_out_ready), .ec_ctrl_ff(ec_ctrl_ff),
  .back_to_back_ff(back_to_back_ff), .tail_cascade_ff(tail_cascade_ff));
